// ==== tb/encode_source.sv ====
// Purpose: encode pulse source standing in for the external encode clock
// Assumes: gap_i stays within 1 to 5 cycles
// Notes: one pulse marks one rising encode edge
`timescale 1ns/10ps
module encode_source (
  input wire logic sys_clk_i,
  input wire logic run_i,
  input wire logic [2:0] gap_i,
  output logic encode_edge_o
);
  logic [2:0] cnt_ff = 3'h0;
  initial encode_edge_o = 1'b0;
  // Gap of 5 cycles at 40 ns is the slowest legal rate
  always @(negedge sys_clk_i) begin
    encode_edge_o <= run_i && cnt_ff == 3'h0;
    cnt_ff <= (cnt_ff == 3'h0) ? gap_i - 3'h1 : cnt_ff - 3'h1;
  end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: random and corner stimulus for the dual converter output block
// Assumes: design follows the hand-over latencies
// Notes: model follows the one-edge lag of the power state, so valid is checked both ways
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  import dual_conv_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sleep = 1'b0;
  logic run = 1'b0;
  logic enc, valid;
  logic [2:0] gap = 3'h1;
  logic [7:0] ga, gb, oe_a, oe_b;
  logic [7:0] corner[4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  pair_s din = '0;
  pair_s exp_w = '0;
  pair_s p[3];
  int bad_count = 0, comparisons = 0, seed = 32'h04898bce, cyc = 0, quiet = 0, cnt = 0, settle = 0, slept = 0;
  initial forever #20 sys_clk_i = ~sys_clk_i;
  encode_source encode_source_inst (.sys_clk_i(sys_clk_i), .run_i(run), .gap_i(gap), .encode_edge_o(enc));
  dual_conv_out dual_conv_out_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .encode_edge_i(enc),
    .sleep_request_i(sleep), .analog_in_first_i(din.first), .analog_in_second_i(din.second),
    .result_bus_first_o(ga), .result_bus_first_oe_o(oe_a), .result_bus_second_o(gb),
    .result_bus_second_oe_o(oe_b), .data_valid_o(valid));
  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > 1000) begin
      bad_count++;
      end_sim();
    end else if (!rst_n_i) begin
      p = '{default: '0};
      exp_w = '0;
      cnt = 0;
      quiet = 0;
      settle = 0;
      slept = 0;
    end else begin
      quiet = sleep ? 0 : quiet + 1;
      // Steps follow the registered power state, one edge behind the sleep input
      if (enc && slept == 0) begin
        exp_w = p[2];
        p[2] = p[1];
        p[1] = p[0];
        p[0] = din;
        if (settle == 0 && !sleep) cnt++;
      end
      if (sleep) begin
        settle = SLEEP_SETTLE_CYC + 1;
        cnt = 0;
      end else if (settle > 0) begin
        settle--;
      end
      slept = sleep;
    end
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      `CHK("first", exp_w.first, ga)
      `CHK("second", exp_w.second, gb)
      if (sleep || !rst_n_i) `CHK("oe", 16'h0, {oe_a, oe_b})
      if (sleep || !rst_n_i) `CHK("valid", 1'b0, valid)
      if (!sleep && rst_n_i && quiet > 1) `CHK("oe", 16'hffff, {oe_a, oe_b})
      if (!sleep && rst_n_i) `CHK("valid", 1'(cnt > 2), valid)
    end
  endtask
  initial begin
    tick(2);
    rst_n_i = 1'b1;
    run = 1'b1;
    repeat (3) begin
      foreach (corner[i]) begin
        din = {corner[i], ~corner[i]};
        gap = 3'h1;
        tick(1);
      end
      repeat (60) begin
        din = 16'($random(seed));
        gap = 3'($unsigned($random(seed)) % 5 + 1);
        tick(1);
      end
      run = 1'b0;
      tick(3);
      sleep = 1'b1;
      tick(5);
      run = 1'b1;
      tick(12);
      run = 1'b0;
      tick(2);
      sleep = 1'b0;
      tick(3);
      run = 1'b1;
      tick(15);
      rst_n_i = 1'b0;
      tick(2);
      rst_n_i = 1'b1;
    end
    tick(20);
    end_sim();
  end
endmodule

// ==== verilog/dual_conv_out.sv ====
// Purpose: digital output side of a dual 8-bit converter with shared encode clock
// Assumes: encode_edge_i pulses one cycle per rising encode edge; analog codes arrive quantised
// Notes: outputs are three-signal pins; enable high while driving
// Contract
// RULE1: Both channels sample together on each rising edge of one shared encode clock.
// RULE2: Each channel has its own 8-bit output bus, never interleaved.
// RULE3: Output words change only on rising encode edges.
// RULE4: A sample's word appears three encode cycles after the capturing edge.
// RULE5: While sleep request is high, all output bits of both channels float.
// RULE6: Controller waits 200 ns after sleep before relying on floating outputs.
// RULE7: After wake, controller waits 200 ns plus three encode cycles for valid data.
// RULE8: Encode rate stays between 5 and 60 MSPS inclusive.
// RULE9: Encode duty cycle near 50 percent at maximum rate.
// RULE10: One sleep input powers both channels down and up together.
// RULE11: Codes are offset binary, top bit set at and above midscale.
`timescale 1ns/10ps
module dual_conv_out
  import dual_conv_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic encode_edge_i,
  input wire logic sleep_request_i,
  input wire logic [WORD_W-1:0] analog_in_first_i,
  input wire logic [WORD_W-1:0] analog_in_second_i,
  output logic [WORD_W-1:0] result_bus_first_o,
  output logic [WORD_W-1:0] result_bus_first_oe_o,
  output logic [WORD_W-1:0] result_bus_second_o,
  output logic [WORD_W-1:0] result_bus_second_oe_o,
  output logic data_valid_o
);
  pair_s held_ff;
  wire pair_s pipe_out;
  pwr_e pwr_ff;
  pwr_e nxt_pwr;
  logic [SETTLE_CNT_W-1:0] settle_ff;
  logic [SETTLE_CNT_W-1:0] nxt_settle;
  logic [1:0] fill_ff;
  logic [1:0] nxt_fill;
  logic drive_ff;

  // Track-and-hold: inputs are taken as codes, already offset binary
  // Freeze follows the registered state, so the edge on which sleep is first seen still steps
  wire in_active = (pwr_ff == PWR_ACTIVE);
  wire in_settle = (pwr_ff == PWR_SETTLE);
  wire in_sleep = (pwr_ff == PWR_SLEEP);
  wire sample_now = encode_edge_i && !in_sleep;
  wire pair_s in_pair = '{first: analog_in_first_i, second: analog_in_second_i}; // RULE11

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      held_ff <= '0;
    end else if (sample_now) begin
      held_ff <= in_pair; // RULE1
    end
  end

  sample_pipe u_pipe_first (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .step_i(sample_now),
    .code_i(held_ff.first),
    .code_o(pipe_out.first)
  );

  sample_pipe u_pipe_second (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .step_i(sample_now),
    .code_i(held_ff.second),
    .code_o(pipe_out.second)
  );

  // Capture edge plus three pipe steps; the last stage is the output word itself

  // Power sequencing: one state for both channels, so they can never diverge
  wire settle_done = (settle_ff == SETTLE_CNT_W'(SLEEP_SETTLE_CYC - 1));
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_settle = settle_ff;
    nxt_fill = fill_ff;
    case (pwr_ff)
      PWR_ACTIVE: begin
        if (sleep_request_i) begin
          nxt_pwr = PWR_SLEEP; // RULE10
        end else if (encode_edge_i && fill_ff != 2'd3) begin
          nxt_fill = fill_ff + 2'd1;
        end
      end
      PWR_SLEEP: begin
        nxt_fill = 2'd0;
        nxt_settle = '0;
        if (!sleep_request_i) begin
          nxt_pwr = PWR_SETTLE;
        end
      end
      PWR_SETTLE: begin
        if (sleep_request_i) begin
          nxt_pwr = PWR_SLEEP;
        end else if (settle_done) begin
          nxt_pwr = PWR_ACTIVE;
        end else begin
          nxt_settle = settle_ff + SETTLE_CNT_W'(1);
        end
      end
      default: nxt_pwr = PWR_SLEEP;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pwr_ff <= PWR_ACTIVE;
    end else begin
      pwr_ff <= nxt_pwr; // RULE10
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      settle_ff <= '0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fill_ff <= 2'd0;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= !sleep_request_i; // RULE5
    end
  end

  // Float immediately on sleep so controllers see it well inside their 200 ns wait
  wire drive_now = drive_ff && !sleep_request_i;
  assign result_bus_first_o = pipe_out.first; // RULE2
  assign result_bus_second_o = pipe_out.second; // RULE2
  assign result_bus_first_oe_o = {WORD_W{drive_now}}; // RULE5
  assign result_bus_second_oe_o = {WORD_W{drive_now}}; // RULE10
  assign data_valid_o = in_active && (fill_ff == 2'd3) && drive_now; // RULE7

  // Checks lean on the single power state, so a split between channels shows at once
  a_sleep_floats: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
    sleep_request_i |-> (result_bus_first_oe_o == '0 && result_bus_second_oe_o == '0))
    else $error("outputs driven during sleep");

  a_channels_same_power: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    result_bus_first_oe_o == result_bus_second_oe_o)
    else $error("channels differ in power state");

  a_word_edge_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
    !$past(sample_now) |-> $stable(pipe_out))
    else $error("output changed without encode edge");

  a_sample_together: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
    sample_now |=> held_ff == $past(in_pair))
    else $error("channels not sampled together");

  a_buses_apart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
    result_bus_first_o == pipe_out.first && result_bus_second_o == pipe_out.second)
    else $error("channel words crossed");

  a_offset_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
    sample_now |=> (held_ff.first >= MIDSCALE) == held_ff.first[WORD_W-1])
    else $error("top bit not midscale flag");

  a_wake_invalid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    $fell(sleep_request_i) |-> !data_valid_o [*5])
    else $error("valid too soon after wake");

  a_float_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
    !sleep_request_i && !$past(sleep_request_i) && $past(rst_n_i)
      |-> (result_bus_first_oe_o == '1 && result_bus_second_oe_o == '1))
    else $error("outputs floating while awake");

  a_oe_all_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
    result_bus_first_oe_o == '0 || result_bus_first_oe_o == '1)
    else $error("output bits split in drive state");

  a_valid_driven: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE5
    data_valid_o |-> (result_bus_first_oe_o == '1 && result_bus_second_oe_o == '1))
    else $error("valid while outputs float");

  a_sleep_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    sleep_request_i |=> in_sleep)
    else $error("sleep request not taken");

  a_frozen_asleep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    in_sleep |=> $stable(held_ff) && $stable(pipe_out))
    else $error("pipeline moved during sleep");

  a_active_stays: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE10
    in_active && !sleep_request_i |=> in_active)
    else $error("left active without sleep");

  a_wake_to_settle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    in_sleep && !sleep_request_i |=> in_settle)
    else $error("wake did not start settling");

  a_settle_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    $rose(in_settle) |-> settle_ff == '0)
    else $error("settle count not cleared");

  a_settle_span: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    $rose(in_active) && $past(rst_n_i) |-> $past(in_settle) && $past(in_settle, 5))
    else $error("settle period too short");

  a_fill_cleared: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    in_sleep |=> fill_ff == 2'd0)
    else $error("encode count kept through sleep");

  a_valid_late: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    $rose(in_active) && $past(rst_n_i) |-> !data_valid_o [*3])
    else $error("valid before three encode edges");

  a_sleep_no_valid: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE7
    sleep_request_i |-> !data_valid_o)
    else $error("valid during sleep");

  a_word_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE3
    !sample_now |=> $stable(result_bus_first_o) && $stable(result_bus_second_o))
    else $error("output word moved between encode edges");
endmodule

// ==== verilog/dual_conv_pkg.sv ====
// Purpose: shared constants and carriers for the dual converter output block
// Assumes: one system clock at 25 MHz; encode rate arrives as a one-cycle enable
// Notes: sample words are already quantised offset-binary codes
package dual_conv_pkg;
  localparam int WORD_W = 8;
  localparam int PIPE_DEPTH = 3;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLEEP_SETTLE_NS = 200;
  localparam int SLEEP_SETTLE_CYC = (SLEEP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 4;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [WORD_W-1:0] MIDSCALE = 8'h80;

  typedef struct packed {
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } pair_s;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SLEEP,
    PWR_SETTLE
  } pwr_e;
endpackage

// ==== verilog/sample_pipe.sv ====
// Purpose: three-stage delay line for one channel's codes, stepped by encode edges
// Assumes: enable is a one-cycle pulse marking a rising encode edge
// Notes: flip-flop storage, one generate loop over stages
`timescale 1ns/10ps
module sample_pipe
  import dual_conv_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic [WORD_W-1:0] code_i,
  output logic [WORD_W-1:0] code_o
);
  logic [WORD_W-1:0] stage_ff [PIPE_DEPTH];

  genvar g;
  generate
    for (g = 0; g < PIPE_DEPTH; g++) begin : g_stage
      wire [WORD_W-1:0] nxt_stage = (g == 0) ? code_i : stage_ff[(g == 0) ? 0 : g-1];
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          stage_ff[g] <= WORD_RESET;
        end else if (step_i) begin
          stage_ff[g] <= nxt_stage; // RULE4
        end
      end
    end
  endgenerate

  assign code_o = stage_ff[PIPE_DEPTH-1]; // RULE3
endmodule
